// ===== src/flash_status_and_mux_port.sv
// Multiplexed parallel programming port, command decode, write
// sequencer front end and status register reads.
// Assumes an array back end on clk that performs erase and program.
`timescale 1ns/1ps
module flash_status_and_mux_port
  import fsp_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                interfaceSelect,
  input  wire logic                rowColStrobe,
  input  wire logic                outputEnableN,
  input  wire logic                writeEnableN,
  input  wire logic                resetN,
  input  wire logic [ROW_W-1:0]    addrPins,
  input  wire logic [DATA_W-1:0]   dataLinesIn,
  output logic [DATA_W-1:0]        dataLinesOut,
  output logic                     dataLinesOeN,
  output logic                     readyBusyOut,
  output logic                     readyBusyOeN,
  input  wire logic                supplyLow,
  input  wire logic                topSectorGuardN,
  input  wire logic                writeProtectN,
  input  wire logic [NUM_SECT-1:0] sectorLock,
  output logic [ADDR_W-1:0]        arrayAddr,
  input  wire logic [DATA_W-1:0]   arrayRdData,
  output logic                     opStart,
  output logic                     opErase,
  output logic [ADDR_W-1:0]        opAddr,
  output logic [DATA_W-1:0]        opData,
  output logic                     opSuspend,
  input  wire logic                opHalted,
  input  wire logic                opDone,
  input  wire logic                opFail
);

  fsp_pins_t      pinsRaw;
  fsp_pins_t      pins;
  fsp_pins_t      pinsPrev;
  logic [ROW_W-1:0] rowAddr;
  logic [COL_W-1:0] colAddr;
  logic [ADDR_W-1:0] fullAddr;
  fsp_read_mode_t readMode;
  fsp_read_mode_t next_readMode;
  fsp_cmd_state_t cmdState;
  fsp_cmd_state_t next_cmdState;
  fsp_seq_state_t seqState;
  fsp_op_t        curOp;
  fsp_op_t        savedOp;
  fsp_op_t        newOp;
  fsp_err_t       setErr;
  logic           nested;
  logic           modeOn;
  logic           portRst;
  logic           weRise;
  logic           rcFall;
  logic           rcRise;
  logic           writeValid;
  logic [DATA_W-1:0] wrData;
  logic           busy;
  logic           startProg;
  logic           startErase;
  logic           clearReq;
  logic           suspendCmd;
  logic           resumeCmd;
  logic           badSeq;
  logic           guarded;
  logic           eraseSusp;
  logic           progSusp;
  logic [7:0]     statusByte;
  logic [3:0]     sector;

  assign pinsRaw = '{interfaceSelect: interfaceSelect,
                     rowColStrobe:    rowColStrobe,
                     outputEnableN:   outputEnableN,
                     writeEnableN:    writeEnableN,
                     resetN:          resetN,
                     supplyLow:       supplyLow,
                     topSectorGuardN: topSectorGuardN,
                     writeProtectN:   writeProtectN,
                     addr:            addrPins,
                     data:            dataLinesIn};

  fsp_sync u_sync (
    .clk     (clk),
    .rst     (rst),
    .pinsIn  (pinsRaw),
    .pinsOut (pins)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      pinsPrev <= PINS_IDLE;
    end else begin
      pinsPrev <= pins;
    end
  end

  // port active only with select high
  // An undriven select pin is held low outside, so the port stays off
  assign modeOn  = pins.interfaceSelect;
  assign portRst = !pins.resetN;
  assign rcFall  = !pins.rowColStrobe && pinsPrev.rowColStrobe;
  assign rcRise  = pins.rowColStrobe && !pinsPrev.rowColStrobe;
  // write on strobe release
  // Data is taken from the last sample while the strobe was still low
  assign weRise     = pins.writeEnableN && !pinsPrev.writeEnableN;
  assign writeValid = weRise && modeOn && pins.resetN &&
                      pinsPrev.outputEnableN;
  assign wrData     = pinsPrev.data;

  always_ff @(posedge clk) begin
    if (rst) begin
      rowAddr <= '0;
      colAddr <= '0;
    end else if (modeOn) begin
      if (rcFall) begin
        rowAddr <= pins.addr;
      end
      if (rcRise) begin
        colAddr <= pins.addr[COL_W-1:0];
      end
    end
  end

  assign fullAddr = {colAddr, rowAddr};
  assign sector   = fullAddr[SECT_HI:SECT_LO];
  assign busy     = (seqState == SEQ_BUSY);
  assign eraseSusp = (seqState == SEQ_HELD) && savedOp.erase;
  assign progSusp  = (seqState == SEQ_HELD) && !savedOp.erase;

  always_comb begin
    next_cmdState = cmdState;
    next_readMode = readMode;
    startProg     = 1'b0;
    startErase    = 1'b0;
    clearReq      = 1'b0;
    suspendCmd    = 1'b0;
    resumeCmd     = 1'b0;
    badSeq        = 1'b0;
    if (portRst) begin
      next_cmdState = CMD_IDLE;
      next_readMode = RD_ARRAY;
    end else if (writeValid) begin
      case (cmdState)
        CMD_WAIT_DATA: begin
          next_cmdState = CMD_IDLE;
          next_readMode = RD_STATUS;
          startProg     = 1'b1;
        end
        CMD_WAIT_CONFIRM: begin
          next_cmdState = CMD_IDLE;
          next_readMode = RD_STATUS;
          if (wrData == CMD_CONFIRM) begin
            startErase = 1'b1;
          end else begin
            badSeq = 1'b1;
          end
        end
        default: begin
          case (wrData)
            CMD_READ_ARRAY: begin
              if (!busy) begin
                next_readMode = RD_ARRAY;
              end
            end
            CMD_STATUS_READ: begin
              next_readMode = RD_STATUS;
            end
            CMD_STATUS_CLEAR: begin
              clearReq = 1'b1;
            end
            CMD_ID_ENTRY: begin
              if (!busy) begin
                next_readMode = RD_ID;
              end
            end
            CMD_ERASE_SETUP: begin
              if (seqState == SEQ_IDLE) begin
                next_cmdState = CMD_WAIT_CONFIRM;
              end
              next_readMode = RD_STATUS;
            end
            CMD_PROG_SETUP, CMD_PROG_ALT: begin
              if (!busy && !progSusp) begin
                next_cmdState = CMD_WAIT_DATA;
              end
              next_readMode = RD_STATUS;
            end
            CMD_SUSPEND: begin
              suspendCmd    = 1'b1;
              next_readMode = RD_STATUS;
            end
            CMD_CONFIRM: begin
              resumeCmd     = 1'b1;
              next_readMode = RD_STATUS;
            end
            default: begin
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmdState <= CMD_IDLE;
      readMode <= RD_ARRAY;
    end else begin
      cmdState <= next_cmdState;
      readMode <= next_readMode;
    end
  end

  assign guarded = sectorLock[sector] ||
                   ((sector == TOP_SECTOR) ? !pins.topSectorGuardN
                                           : !pins.writeProtectN);
  assign newOp = '{erase: startErase, addr: fullAddr, data: wrData};

  always_comb begin
    setErr = '0;
    if (badSeq) begin
      setErr.eraseErr = 1'b1;
      setErr.progErr  = 1'b1;
    end
    if (startProg || startErase) begin
      if (guarded) begin
        setErr.protect = 1'b1;
      end else if (pins.supplyLow) begin
        setErr.supplyLow = 1'b1;
      end
    end
    if (busy && opDone) begin
      setErr.eraseErr  = setErr.eraseErr | (opFail && curOp.erase);
      setErr.progErr   = setErr.progErr | (opFail && !curOp.erase);
      setErr.supplyLow = setErr.supplyLow | pins.supplyLow;
    end
  end

  // Write sequencer front end; the back end runs the algorithm
  always_ff @(posedge clk) begin
    if (rst) begin
      seqState  <= SEQ_IDLE;
      curOp     <= '0;
      savedOp   <= '0;
      nested    <= 1'b0;
      opStart   <= 1'b0;
      opSuspend <= 1'b0;
    end else begin
      opStart <= 1'b0;
      case (seqState)
        SEQ_IDLE: begin
          if ((startProg || startErase) && !guarded && !pins.supplyLow) begin
            seqState <= SEQ_BUSY;
            curOp    <= newOp;
            opStart  <= 1'b1;
          end
        end
        SEQ_BUSY: begin
          if (opDone) begin
            opSuspend <= nested;
            nested    <= 1'b0;
            seqState  <= nested ? SEQ_HELD : SEQ_IDLE;
            curOp     <= nested ? savedOp : curOp;
          end else if (opSuspend && opHalted && !nested) begin
            seqState <= SEQ_HELD;
            savedOp  <= curOp;
          end else if (suspendCmd && !nested) begin
            opSuspend <= 1'b1;
          end
        end
        SEQ_HELD: begin
          // Erase may host one program elsewhere; no deeper nesting
          if (startProg && savedOp.erase && !guarded &&
              !pins.supplyLow) begin
            seqState <= SEQ_BUSY;
            curOp    <= newOp;
            nested   <= 1'b1;
            opStart  <= 1'b1;
          end else if (resumeCmd) begin
            seqState  <= SEQ_BUSY;
            curOp     <= savedOp;
            opSuspend <= 1'b0;
          end
        end
        default: begin
          seqState <= SEQ_IDLE;
        end
      endcase
    end
  end

  assign opErase = curOp.erase;
  assign opAddr  = curOp.addr;
  assign opData  = curOp.data;

  fsp_status u_status (
    .clk       (clk),
    .rst       (rst),
    .ready     (!busy),
    .eraseSusp (eraseSusp),
    .progSusp  (progSusp),
    .setErr    (setErr),
    .clear     (clearReq),
    .status    (statusByte)
  );

  // Read data path
  always_ff @(posedge clk) begin
    if (rst) begin
      dataLinesOut <= '0;
      arrayAddr    <= '0;
    end else begin
      arrayAddr <= fullAddr;
      case (readMode)
        RD_STATUS: dataLinesOut <= statusByte;
        RD_ID:     dataLinesOut <= rowAddr[ID_SEL_BIT] ? PART_CODE
                                                       : MAKER_CODE;
        default:   dataLinesOut <= arrayRdData;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dataLinesOeN <= 1'b1;
    end else begin
      dataLinesOeN <= !(modeOn && pins.resetN && !pins.outputEnableN &&
                        pins.writeEnableN);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      readyBusyOut <= 1'b0;
      readyBusyOeN <= 1'b1;
    end else begin
      readyBusyOut <= 1'b0;
      readyBusyOeN <= !(modeOn && busy);
    end
  end

endmodule

// ===== src/fsp_pkg.sv
// Shared constants, command codes, status layout and carrier types
// for the flash status and multiplexed programming port.
// Assumes a single 50 MHz clock domain inside the device.
package fsp_pkg;

  localparam int ADDR_W   = 20;
  localparam int ROW_W    = 11;
  localparam int COL_W    = 9;
  localparam int DATA_W   = 8;
  localparam int SECT_HI  = 19;
  localparam int SECT_LO  = 16;
  localparam int NUM_SECT = 16;
  localparam int ID_SEL_BIT = 0;

  localparam logic [3:0] TOP_SECTOR = 4'hf;

  // Command bytes
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
  localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
  localparam logic [7:0] CMD_PROG_ALT     = 8'h10;
  localparam logic [7:0] CMD_SUSPEND      = 8'hb0;
  localparam logic [7:0] CMD_ID_ENTRY     = 8'h90;
  localparam logic [7:0] CMD_STATUS_READ  = 8'h70;
  localparam logic [7:0] CMD_STATUS_CLEAR = 8'h50;

  // Status bit positions
  localparam int ST_READY      = 7;
  localparam int ST_ERASE_SUSP = 6;
  localparam int ST_ERASE_ERR  = 5;
  localparam int ST_PROG_ERR   = 4;
  localparam int ST_SUPPLY_LOW = 3;
  localparam int ST_PROG_SUSP  = 2;
  localparam int ST_PROTECT    = 1;
  localparam int ST_RSVD       = 0;

  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic       RSVD_VALUE   = 1'b0;

  // Identifier bytes; values are arbitrary
  localparam logic [7:0] MAKER_CODE  = 8'h5a;
  localparam logic [7:0] PART_CODE   = 8'ha5;

  typedef enum logic [1:0] {
    RD_ARRAY  = 2'b00,
    RD_STATUS = 2'b01,
    RD_ID     = 2'b11
  } fsp_read_mode_t;

  typedef enum logic [1:0] {
    CMD_IDLE         = 2'b00,
    CMD_WAIT_DATA    = 2'b01,
    CMD_WAIT_CONFIRM = 2'b11
  } fsp_cmd_state_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_BUSY = 2'b01,
    SEQ_HELD = 2'b11
  } fsp_seq_state_t;

  typedef struct packed {
    logic              erase;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fsp_op_t;

  typedef struct packed {
    logic eraseErr;
    logic progErr;
    logic supplyLow;
    logic protect;
  } fsp_err_t;

  typedef struct packed {
    logic              interfaceSelect;
    logic              rowColStrobe;
    logic              outputEnableN;
    logic              writeEnableN;
    logic              resetN;
    logic              supplyLow;
    logic              topSectorGuardN;
    logic              writeProtectN;
    logic [ROW_W-1:0]  addr;
    logic [DATA_W-1:0] data;
  } fsp_pins_t;

  // Pin levels with every strobe idle and the port deselected
  localparam fsp_pins_t PINS_IDLE = '{interfaceSelect: 1'b0,
                                      rowColStrobe:    1'b1,
                                      outputEnableN:   1'b1,
                                      writeEnableN:    1'b1,
                                      resetN:          1'b1,
                                      supplyLow:       1'b0,
                                      topSectorGuardN: 1'b1,
                                      writeProtectN:   1'b1,
                                      addr:            '0,
                                      data:            '0};

endpackage

// ===== src/fsp_sync.sv
// Two-flop synchroniser for the whole pin bundle.
// Assumes every bundled pin is asynchronous to clk.
`timescale 1ns/1ps
module fsp_sync
  import fsp_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire fsp_pins_t pinsIn,
  output fsp_pins_t      pinsOut
);

  fsp_pins_t stage1;

  // Stage one feeds stage two only
  always_ff @(posedge clk) begin
    if (rst) begin
      // Idle levels, so no false strobe edge follows reset
      stage1  <= PINS_IDLE;
      pinsOut <= PINS_IDLE;
    end else begin
      stage1  <= pinsIn;
      pinsOut <= stage1;
    end
  end

endmodule

// ===== src/fsp_status.sv
// Operation status byte: live sequencer bits plus sticky error flags.
// Assumes set requests come only from the write sequencer.
`timescale 1ns/1ps
module fsp_status
  import fsp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ready,
  input  wire logic       eraseSusp,
  input  wire logic       progSusp,
  input  wire fsp_err_t   setErr,
  input  wire logic       clear,
  output logic [7:0]      status
);

  fsp_err_t errs;

  // sticky flags
  // Set wins over a clear in the same cycle so no failure is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      errs <= '0;
    end else begin
      errs <= setErr | (clear ? fsp_err_t'('0) : errs);
    end
  end

  always_comb begin
    status                = '0;
    status[ST_READY]      = ready;
    status[ST_ERASE_SUSP] = eraseSusp;
    status[ST_PROG_SUSP]  = progSusp;
    status[ST_ERASE_ERR]  = errs.eraseErr;
    status[ST_PROG_ERR]   = errs.progErr;
    status[ST_SUPPLY_LOW] = errs.supplyLow;
    status[ST_PROTECT]    = errs.protect;
    status[ST_RSVD]       = RSVD_VALUE;
  end

endmodule

// ===== tb/fsp_programmer.sv
// Programmer model: drives the parallel port pins, reads bytes back.
// Assumes the bench clock; every pin moves on a falling edge only.
`timescale 1ns/1ps
module fsp_programmer
  import fsp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] bus,
  output logic                   rowColStrobe,
  output logic                   outputEnableN,
  output logic                   writeEnableN,
  output logic [ROW_W-1:0]       addrPins,
  output logic [DATA_W-1:0]      drive
);
  initial begin
    rowColStrobe  = 1'b1;
    outputEnableN = 1'b1;
    writeEnableN  = 1'b1;
    addrPins      = '0;
    drive         = 8'h00;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic set_addr(input logic [ADDR_W-1:0] a);
    addrPins = a[10:0];
    hold(4);
    rowColStrobe = 1'b0;
    hold(4);
    addrPins = {2'b00, a[19:11]};
    hold(4);
    rowColStrobe = 1'b1;
    hold(4);
  endtask

  // byte written with output enable high
  task automatic wr(input logic [DATA_W-1:0] b);
    drive = b;
    writeEnableN = 1'b0;
    hold(5);
    writeEnableN = 1'b1;
    hold(1);
    // Released lines must not keep showing the byte
    drive = ~b;
    hold(4);
  endtask

  task automatic rd(output logic [DATA_W-1:0] b);
    outputEnableN = 1'b0;
    hold(6);
    b = bus;
    outputEnableN = 1'b1;
    hold(5);
  endtask
endmodule

// ===== tb/fsp_properties.sv
// Concurrent checks on the parallel port top-level pins.
// Assumes pins are held steady for several clocks at a time.
`timescale 1ns/1ps
module fsp_properties
  import fsp_pkg::*;
(
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                interfaceSelect,
  input wire logic                outputEnableN,
  input wire logic                writeEnableN,
  input wire logic                resetN,
  input wire logic                supplyLow,
  input wire logic [NUM_SECT-1:0] sectorLock,
  input wire logic                dataLinesOeN,
  input wire logic                readyBusyOeN,
  input wire logic                opStart,
  input wire logic [ADDR_W-1:0]   opAddr,
  input wire logic                opDone,
  input wire logic                opSuspend
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Pins need up to four clocks to reach the outputs
  a_oe_float: assert property (
    outputEnableN [*5] |-> dataLinesOeN)
    else $error("data lines driven with output enable high");
  a_read_drive: assert property (
    (!outputEnableN && writeEnableN && resetN && interfaceSelect) [*6]
    |-> !dataLinesOeN)
    else $error("data lines not driven during read");
  a_write_float: assert property (
    !writeEnableN [*5] |-> dataLinesOeN)
    else $error("data lines driven during write strobe");
  a_port_off: assert property (
    !interfaceSelect [*5] |-> dataLinesOeN)
    else $error("data lines driven with port deselected");
  a_busy_start: assert property (
    opStart |-> ##[0:1] !readyBusyOeN)
    else $error("busy pin not pulled at operation start");
  a_busy_hold: assert property (
    !readyBusyOeN && !opDone && !$past(opDone) && !opSuspend
    |=> !readyBusyOeN)
    else $error("busy pin released before operation end");
  a_done_release: assert property (
    opDone && !opSuspend |=> ##[0:1] readyBusyOeN)
    else $error("busy pin not released after operation end");
  a_lock_refuse: assert property (
    opStart |=> !sectorLock[opAddr[SECT_HI:SECT_LO]])
    else $error("operation started on a locked sector");
  a_supply_refuse: assert property (
    supplyLow [*6] |-> !opStart)
    else $error("operation started with supply at lockout");
endmodule

bind flash_status_and_mux_port fsp_properties chk (
  .clk, .rst, .interfaceSelect, .outputEnableN, .writeEnableN, .resetN,
  .supplyLow, .sectorLock, .dataLinesOeN, .readyBusyOeN, .opStart,
  .opAddr, .opDone, .opSuspend
);

// ===== tb/tb.sv
// Self-checking bench: programmer model on the pins, array back end
// modelled inline with a settable operation length (opLen: 20 clocks, 300 in the suspend test).
`timescale 1ns/1ps
module tb
  import fsp_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, interfaceSelect = 1'b1, resetN = 1'b1;
  logic supplyLow = 1'b0, topSectorGuardN = 1'b1, writeProtectN = 1'b1;
  logic opDone = 1'b0, opFail = 1'b0, failNext = 1'b0, busy = 1'b0;
  logic [NUM_SECT-1:0] sectorLock = '0;
  logic [ADDR_W-1:0] arrayAddr, opAddr;
  logic [DATA_W-1:0] dataLinesOut, dataLinesIn, arrayRdData, bus, opData;
  logic readyBusyOut, opErase;
  logic rowColStrobe, outputEnableN, writeEnableN, dataLinesOeN;
  logic readyBusyOeN, opStart, opSuspend, opHalted;
  logic [ROW_W-1:0] addrPins;
  int opLen = 20, cnt, starts = 0, errorCnt = 0, checksDone = 0;

  initial forever #10 clk = ~clk;

  assign bus = dataLinesOeN ? dataLinesIn : dataLinesOut;
  assign arrayRdData = arrayAddr[7:0] ^ arrayAddr[19:12];
  assign opHalted = busy && opSuspend;

  flash_status_and_mux_port DUT (
    .clk, .rst, .interfaceSelect, .rowColStrobe, .outputEnableN,
    .writeEnableN, .resetN, .addrPins, .dataLinesIn, .dataLinesOut,
    .dataLinesOeN, .readyBusyOut, .readyBusyOeN, .supplyLow,
    .topSectorGuardN, .writeProtectN, .sectorLock, .arrayAddr,
    .arrayRdData, .opStart, .opErase, .opAddr, .opData, .opSuspend,
    .opHalted, .opDone, .opFail
  );

  fsp_programmer P (
    .clk, .bus, .rowColStrobe, .outputEnableN, .writeEnableN, .addrPins,
    .drive(dataLinesIn)
  );

  // Back end: stalls while suspended, pulses done with the chosen result
  always @(posedge clk) begin
    opDone <= 1'b0;
    opFail <= 1'b0;
    if (opStart) begin
      starts <= starts + 1;
      busy   <= 1'b1;
      cnt    <= opLen;
    end else if (busy && !opSuspend) begin
      if (cnt == 0) begin
        busy   <= 1'b0;
        opDone <= 1'b1;
        opFail <= failNext;
      end else
        cnt <= cnt - 1;
    end
  end

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    checksDone++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic st(input logic [7:0] exp, input logic [7:0] mask);
    logic [7:0] b;
    P.rd(b);
    check("status", exp & mask, b & mask);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (readyBusyOeN !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n == 2000) begin
      errorCnt++;
      report_and_stop();
    end
  endtask

  task automatic prog(input logic [19:0] a, input logic [7:0] d);
    P.set_addr(a);
    // Either setup code starts a program; address bit 4 picks one
    P.wr(a[4] ? CMD_PROG_ALT : CMD_PROG_SETUP);
    P.wr(d);
  endtask

  task automatic erase(input logic [19:0] a);
    P.set_addr(a);
    P.wr(CMD_ERASE_SETUP);
    P.wr(CMD_CONFIRM);
  endtask

  // Flag must survive other commands and go only on clear
  task automatic sticky(input logic [7:0] exp);
    P.wr(CMD_STATUS_READ);
    st(exp, 8'hfe);
    P.wr(CMD_READ_ARRAY);
    P.wr(CMD_STATUS_READ);
    st(exp, 8'hfe);
    P.wr(CMD_STATUS_CLEAR);
    P.wr(CMD_STATUS_READ);
    st(STATUS_RESET, 8'hfe);
  endtask

  task automatic t_status();
    P.wr(CMD_STATUS_READ);
    st(STATUS_RESET, 8'hfe);
    st(STATUS_RESET, 8'hfe);
    check("float", 8'h01, {7'h0, dataLinesOeN});
    $display("test status done");
  endtask

  task automatic t_op(input logic er, input logic fl,
                      input logic [7:0] exp);
    int s;
    s = starts;
    failNext = fl;
    if (er) erase(20'h10000);
    else prog(20'h00123, 8'h3c);
    check("start", 8'h01, 8'(starts - s));
    check("busy", 8'h00, {7'h0, readyBusyOeN});
    check("busy level", 8'h00, {7'h0, readyBusyOut});
    check("op kind", {7'h0, er}, {7'h0, opErase});
    if (!er) check("op data", 8'h3c, opData);
    // Supply drops only after the start; the flag is judged at the end
    supplyLow = fl && !er;
    if (er) P.wr(CMD_STATUS_READ);
    st(8'h00, 8'h80);
    wait_ready();
    supplyLow = 1'b0;
    sticky(exp);
    $display("test operation done");
  endtask

  task automatic t_improper();
    P.wr(CMD_ERASE_SETUP);
    P.wr(8'h00);
    sticky(8'hb0);
    $display("test improper done");
  endtask

  task automatic t_refuse(input int k);
    int s;
    s = starts;
    supplyLow = (k == 0);
    sectorLock = (k == 1) ? 16'h0004 : '0;
    writeProtectN = (k != 2);
    topSectorGuardN = (k != 3);
    if (k[0]) erase({(k == 3) ? 4'hf : 4'(k + 1), 16'h0100});
    else prog({(k == 2) ? 4'h3 : 4'h1, 16'h0100}, 8'h00);
    check("refused", 8'h00, 8'(starts - s));
    sticky((k == 0) ? 8'h88 : 8'h82);
    supplyLow = 1'b0;
    sectorLock = '0;
    writeProtectN = 1'b1;
    topSectorGuardN = 1'b1;
    $display("test refuse %0d done", k);
  endtask

  task automatic t_susp(input logic er);
    opLen = 300;
    failNext = 1'b0;
    if (er) erase(20'h40000);
    else prog(20'h40010, 8'h55);
    P.wr(CMD_SUSPEND);
    P.wr(CMD_STATUS_READ);
    st(er ? 8'hc0 : 8'h84, 8'hfe);
    P.wr(CMD_CONFIRM);
    opLen = 20;
    wait_ready();
    sticky(STATUS_RESET);
    $display("test suspend done");
  endtask

  task automatic t_array();
    logic [7:0] b;
    P.wr(CMD_READ_ARRAY);
    P.set_addr(20'ha5b3c);
    P.rd(b);
    check("array", 8'h3c ^ 8'ha5, b);
    check("float", 8'h01, {7'h0, dataLinesOeN});
    P.wr(CMD_ID_ENTRY);
    P.rd(b);
    check("id", MAKER_CODE, b);
    $display("test array done");
  endtask

  task automatic t_port_off();
    interfaceSelect = 1'b0;
    P.outputEnableN = 1'b0;
    repeat (8) @(negedge clk);
    check("port off", 8'h01, {7'h0, dataLinesOeN});
    interfaceSelect = 1'b1;
    resetN = 1'b0;
    repeat (8) @(negedge clk);
    check("reset float", 8'h01, {7'h0, dataLinesOeN});
    P.outputEnableN = 1'b1;
    resetN = 1'b1;
    repeat (6) @(negedge clk);
    $display("test port off done");
  endtask

  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_status();
    t_op(1'b0, 1'b0, STATUS_RESET);
    t_op(1'b0, 1'b1, 8'h98);
    t_op(1'b1, 1'b1, 8'ha0);
    t_improper();
    for (int k = 0; k < 4; k++)
      t_refuse(k);
    t_susp(1'b1);
    t_susp(1'b0);
    t_array();
    t_port_off();
    report_and_stop();
  end
endmodule
